// ==== rtl/power_status_telemetry_regs.sv ====
`timescale 1ns/1ps
`include "power_status_params.svh"

module power_status_telemetry_regs
   import power_status_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input cmd_req_t i_req,
   input fault_conds_t i_conds,
   input comm_events_t i_comm,
   input telemetry_t i_tele,
   input wire logic i_tele_sample,
   input wire logic [4:0] i_vout_exponent,
   output cmd_rsp_t o_rsp,
   output logic o_alert,
   output logic o_input_summary,
   output logic [15:0] o_summary_word
);

   // ==========================================================
   // command decode

   cmd_kind_t kind;
   logic is_read;
   logic is_write;
   logic clear_faults;
   logic bad_command;

   // a request lives for exactly one edge; valid qualifies every field
   assign is_read = i_req.valid & ~i_req.write;
   assign is_write = i_req.valid & i_req.write;

   always_comb begin
      case (i_req.code)
         `CMD_INPUT_STATUS,
         `CMD_EXT_TEMP_STATUS,
         `CMD_COMM_STATUS,
         `CMD_VENDOR_STATUS: begin
            kind = KIND_STATUS;
         end
         `CMD_INPUT_VOLTAGE_READING,
         `CMD_OUTPUT_VOLTAGE_READING,
         `CMD_OUTPUT_CURRENT_READING,
         `CMD_READ_EXT_TEMP,
         `CMD_READ_CHIP_TEMP: begin
            kind = KIND_TELEMETRY;
         end
         `CMD_OUTPUT_FORMAT: begin
            kind = KIND_FORMAT;
         end
         `CMD_CLEAR_FAULTS: begin
            kind = KIND_CLEAR;
         end
         default: begin
            kind = KIND_BAD;
         end
      endcase
   end

   // clear-faults is a send-only command; reading it is as bad as an
   // unknown code. writes to the read-only codes are dropped silently
   assign clear_faults = is_write & (kind == KIND_CLEAR);

   always_comb begin
      bad_command = 1'b0;
      if (i_req.valid) begin
         if (kind == KIND_BAD) begin
            bad_command = 1'b1;
         end else if (is_read & (kind == KIND_CLEAR)) begin
            bad_command = 1'b1;
         end
      end
   end

   // ==========================================================
   // set vectors for each status byte

   logic [7:0] set_input;
   logic [7:0] set_temp;
   logic [7:0] set_comm;
   logic [7:0] set_vendor;

   // set vectors are levels; the latches turn them into sticky flags
   always_comb begin
      set_input = `RESET_STATUS;
      set_input[`BIT_IN_UV_FAULT] = i_conds.input_undervolt_fault;
      set_input[`BIT_IN_UV_WARN] = i_conds.input_undervolt_warning;
      set_input[`BIT_IN_OV_WARN] = i_conds.input_overvolt_warning;
      set_input[`BIT_IN_OV_FAULT] = i_conds.input_overvolt_fault;
   end

   always_comb begin
      set_temp = `RESET_STATUS;
      set_temp[`BIT_OT_WARN] = i_conds.external_overtemp_warning;
      set_temp[`BIT_OT_FAULT] = i_conds.external_overtemp_fault;
   end

   always_comb begin
      set_comm = `RESET_STATUS;
      set_comm[`BIT_BUS_FAULT] = i_comm.bus_timeout_format_fault;
      set_comm[`BIT_PEC_FAULT] = i_comm.packet_check_fault;
      // engine-reported and locally decoded bad codes both count
      set_comm[`BIT_CMD_FAULT] = i_comm.bad_command_fault | bad_command;
   end

   always_comb begin
      set_vendor = `RESET_STATUS;
      set_vendor[`BIT_OT_WARN] = i_conds.onchip_overtemp_warning;
      set_vendor[`BIT_OT_FAULT] = i_conds.onchip_overtemp_fault;
   end

   // ==========================================================
   // sticky status bytes

   logic [7:0] input_voltage_status;
   logic [7:0] external_temp_status;
   logic [7:0] comm_fault_status;
   logic [7:0] vendor_specific_status;

   status_flag_latch #(
      .SUPPORTED_MASK(`MASK_INPUT_STATUS)
   ) u_input_status (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(clear_faults),
      .i_set(set_input),
      .o_flags(input_voltage_status)
   );

   status_flag_latch #(
      .SUPPORTED_MASK(`MASK_TEMP_STATUS)
   ) u_temp_status (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(clear_faults),
      .i_set(set_temp),
      .o_flags(external_temp_status)
   );

   status_flag_latch #(
      .SUPPORTED_MASK(`MASK_COMM_STATUS)
   ) u_comm_status (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(clear_faults),
      .i_set(set_comm),
      .o_flags(comm_fault_status)
   );

   status_flag_latch #(
      .SUPPORTED_MASK(`MASK_VENDOR_STATUS)
   ) u_vendor_status (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_clear(clear_faults),
      .i_set(set_vendor),
      .o_flags(vendor_specific_status)
   );

   // ==========================================================
   // telemetry words

   telemetry_t tele;

   telemetry_snapshot u_tele (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_sample(i_tele_sample),
      .i_values(i_tele),
      .o_values(tele)
   );

   // ==========================================================
   // read data select

   logic [15:0] next_data;
   logic next_two_bytes;
   logic [7:0] output_format_byte;

   // linear mode in the upper field, signed exponent below it
   assign output_format_byte = {`FORMAT_MODE_LINEAR, i_vout_exponent};

   always_comb begin
      next_data = `RESET_WORD;
      next_two_bytes = 1'b0;
      if (is_read) begin
         case (i_req.code)
            `CMD_OUTPUT_FORMAT: begin
               next_data = {8'h00, output_format_byte};
            end
            `CMD_INPUT_STATUS: begin
               next_data = {8'h00, input_voltage_status};
            end
            `CMD_EXT_TEMP_STATUS: begin
               next_data = {8'h00, external_temp_status};
            end
            `CMD_COMM_STATUS: begin
               next_data = {8'h00, comm_fault_status};
            end
            `CMD_VENDOR_STATUS: begin
               next_data = {8'h00, vendor_specific_status};
            end
            `CMD_INPUT_VOLTAGE_READING: begin
               next_data = tele.input_voltage;
               next_two_bytes = 1'b1;
            end
            `CMD_OUTPUT_VOLTAGE_READING: begin
               // mantissa only; the exponent lives in the format byte
               next_data = tele.output_voltage;
               next_two_bytes = 1'b1;
            end
            `CMD_OUTPUT_CURRENT_READING: begin
               next_data = tele.output_current;
               next_two_bytes = 1'b1;
            end
            `CMD_READ_EXT_TEMP: begin
               next_data = tele.external_temperature_value;
               next_two_bytes = 1'b1;
            end
            `CMD_READ_CHIP_TEMP: begin
               next_data = tele.onchip_temperature_value;
               next_two_bytes = 1'b1;
            end
            default: begin
               next_data = `RESET_WORD;
               next_two_bytes = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // response register
   // every request gets exactly one answer the next cycle, so the
   // engine never has to wait and needs no timeout of its own

   logic rsp_valid;
   logic rsp_error;
   logic rsp_two_bytes;
   logic [15:0] rsp_data;

   // the carrier only bundles flop outputs; no logic sits on the port
   assign o_rsp = '{valid: rsp_valid, error: rsp_error, two_bytes: rsp_two_bytes,
                    data: rsp_data};

   // valid is a one-cycle pulse; it alone drops back between answers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= i_req.valid;
      end
   end

   // the payload holds between answers, so the engine may shift a
   // word out over several bus cycles without keeping a copy
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_error <= 1'b0;
      end else if (i_req.valid) begin
         rsp_error <= bad_command;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_two_bytes <= 1'b0;
      end else if (i_req.valid) begin
         rsp_two_bytes <= next_two_bytes;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsp_data <= `RESET_WORD;
      end else if (i_req.valid) begin
         rsp_data <= next_data;
      end
   end

   // ==========================================================
   // alert line and summary
   // the alert follows the latched flags, so a clear drops it one
   // cycle later, and only when no condition persists

   logic any_flag;
   logic any_input;

   assign any_flag = |{input_voltage_status, external_temp_status,
                       comm_fault_status, vendor_specific_status};
   assign any_input = |input_voltage_status;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_alert <= 1'b0;
      end else begin
         o_alert <= any_flag;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_input_summary <= 1'b0;
      end else begin
         o_input_summary <= any_input;
      end
   end

   // only the input bit of the summary word is kept here; the other
   // summary bits belong to logic outside this bank
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_summary_word <= `RESET_WORD;
      end else begin
         o_summary_word <= `RESET_WORD;
         o_summary_word[`BIT_SUMMARY_INPUT] <= any_input;
      end
   end

endmodule

// ==== inc/power_status_params.svh ====
`ifndef POWER_STATUS_PARAMS_SVH
`define POWER_STATUS_PARAMS_SVH

// ==========================================================
// command codes seen by the protocol engine
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_OUTPUT_FORMAT 8'h20
`define CMD_INPUT_STATUS 8'h30
`define CMD_EXT_TEMP_STATUS 8'h31
`define CMD_COMM_STATUS 8'h32
`define CMD_VENDOR_STATUS 8'h33
`define CMD_INPUT_VOLTAGE_READING 8'h40
`define CMD_OUTPUT_VOLTAGE_READING 8'h41
`define CMD_OUTPUT_CURRENT_READING 8'h42
`define CMD_READ_EXT_TEMP 8'h43
`define CMD_READ_CHIP_TEMP 8'h44

// ==========================================================
// field positions
`define BIT_IN_UV_FAULT 4
`define BIT_IN_UV_WARN 5
`define BIT_IN_OV_WARN 6
`define BIT_IN_OV_FAULT 7
`define BIT_OT_WARN 6
`define BIT_OT_FAULT 7
`define BIT_BUS_FAULT 1
`define BIT_PEC_FAULT 5
`define BIT_CMD_FAULT 7
`define BIT_SUMMARY_INPUT 13
`define FORMAT_EXP_MSB 4

// ==========================================================
// supported-bit masks and reset values
`define MASK_INPUT_STATUS 8'hF0
`define MASK_TEMP_STATUS 8'hC0
`define MASK_COMM_STATUS 8'hA2
`define MASK_VENDOR_STATUS 8'hC0
`define RESET_STATUS 8'h00
`define RESET_WORD 16'h0000
`define FORMAT_MODE_LINEAR 3'h0

`endif

// ==== inc/power_status_pkg.sv ====
package power_status_pkg;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic input_undervolt_fault;
      logic input_undervolt_warning;
      logic input_overvolt_warning;
      logic input_overvolt_fault;
      logic external_overtemp_warning;
      logic external_overtemp_fault;
      logic onchip_overtemp_warning;
      logic onchip_overtemp_fault;
   } fault_conds_t;

   typedef struct packed {
      logic bus_timeout_format_fault;
      logic packet_check_fault;
      logic bad_command_fault;
   } comm_events_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
   } cmd_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic two_bytes;
      logic [15:0] data;
   } cmd_rsp_t;

   typedef struct packed {
      logic [15:0] input_voltage;
      logic [15:0] output_voltage;
      logic [15:0] output_current;
      logic [15:0] external_temperature_value;
      logic [15:0] onchip_temperature_value;
   } telemetry_t;

   typedef enum {
      KIND_STATUS,
      KIND_TELEMETRY,
      KIND_FORMAT,
      KIND_CLEAR,
      KIND_BAD
   } cmd_kind_t;

endpackage

// ==== rtl/status_flag_latch.sv ====
`timescale 1ns/1ps
`include "power_status_params.svh"

module status_flag_latch #(
   parameter logic [7:0] SUPPORTED_MASK = 8'hFF
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   input wire logic [7:0] i_set,
   output logic [7:0] o_flags
);

   // ==========================================================
   // per-bit sticky flags
   localparam logic [7:0] RESET_FLAGS = `RESET_STATUS;

   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         if (SUPPORTED_MASK[b]) begin : g_sup
            logic flag;
            // set beats clear so a persisting condition re-latches at once
            always_ff @(posedge i_clk or negedge i_rstn) begin
               if (!i_rstn) begin
                  flag <= RESET_FLAGS[b];
               end else begin
                  flag <= (flag & ~i_clear) | i_set[b];
               end
            end
            assign o_flags[b] = flag;
         end else begin : g_none
            assign o_flags[b] = 1'b0;
         end
      end
   endgenerate

endmodule

// ==== rtl/telemetry_snapshot.sv ====
`timescale 1ns/1ps
`include "power_status_params.svh"

module telemetry_snapshot
   import power_status_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sample,
   input telemetry_t i_values,
   output telemetry_t o_values
);

   // ==========================================================
   // capture on the sample strobe so a read never sees a half-updated word
   logic [4:0][15:0] in_words;
   logic [4:0][15:0] held;

   assign in_words = i_values;
   assign o_values = held;

   genvar w;
   generate
      for (w = 0; w < 5; w++) begin : g_word
         logic [15:0] word;
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               word <= `RESET_WORD;
            end else if (i_sample) begin
               word <= in_words[w];
            end
         end
         assign held[w] = word;
      end
   endgenerate

endmodule

// ==== bench/bus_host_model.sv ====
`timescale 1ns/1ps
module bus_host_model
   import power_status_pkg::*;
(
   input wire logic i_clk,
   input cmd_rsp_t i_rsp,
   output cmd_req_t o_req
);
   initial o_req = '0;
   // idle bus shows the inverted last code, so a stale code can never look valid
   task automatic xfer(input logic w, input logic [7:0] c, output cmd_rsp_t r);
      @(posedge i_clk);
      o_req <= '{valid: 1'b1, write: w, code: c};
      @(posedge i_clk);
      o_req <= '{valid: 1'b0, write: ~w, code: ~c};
      #1;
      r = i_rsp;
   endtask
endmodule

// ==== bench/power_status_props.sv ====
`timescale 1ns/1ps
`include "power_status_params.svh"
module power_status_props
   import power_status_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input cmd_req_t i_req,
   input fault_conds_t i_conds,
   input comm_events_t i_comm,
   input telemetry_t i_tele,
   input wire logic i_tele_sample,
   input wire logic [4:0] i_vout_exponent,
   input cmd_rsp_t o_rsp,
   input wire logic o_alert,
   input wire logic o_input_summary,
   input wire logic [15:0] o_summary_word
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic rd, clr, bad, tele_rd;
   assign rd = i_req.valid && !i_req.write;
   assign clr = i_req.valid && i_req.write && i_req.code == `CMD_CLEAR_FAULTS;
   assign tele_rd = rd && i_req.code inside {[`CMD_INPUT_VOLTAGE_READING:`CMD_READ_CHIP_TEMP]};
   assign bad = i_req.valid && (!(i_req.code inside {`CMD_CLEAR_FAULTS, `CMD_OUTPUT_FORMAT,
      [`CMD_INPUT_STATUS:`CMD_VENDOR_STATUS], [`CMD_INPUT_VOLTAGE_READING:`CMD_READ_CHIP_TEMP]})
      || (rd && i_req.code == `CMD_CLEAR_FAULTS));
   // ==========
   // response shape
   a_tele_width: assert property (tele_rd |=> o_rsp.valid && o_rsp.two_bytes && !o_rsp.error)
      else $error("telemetry read not answered as a word");
   a_tele_capture: assert property (i_tele_sample ##1 !i_tele_sample ##1
      (rd && i_req.code == `CMD_INPUT_VOLTAGE_READING) |=> o_rsp.data == $past(i_tele.input_voltage, 3))
      else $error("input voltage word not the sampled value");
   a_format_exp: assert property (rd && i_req.code == `CMD_OUTPUT_FORMAT
      |=> o_rsp.data == {11'h000, $past(i_vout_exponent)})
      else $error("format byte does not carry the exponent");
   a_unsup_zero: assert property (rd && i_req.code == `CMD_INPUT_STATUS
      |=> o_rsp.data[15:8] == 8'h00 && o_rsp.data[3:0] == 4'h0 && !o_rsp.two_bytes)
      else $error("unsupported input status bits not zero");
   a_bad_code: assert property (bad |=> o_rsp.error && o_rsp.data == 16'h0000 ##1 o_alert)
      else $error("bad command not refused and flagged");
   // ==========
   // flags
   a_input_flag: assert property (|i_conds[7:4] |-> ##2 o_input_summary && o_alert)
      else $error("input condition did not reach summary");
   a_other_alert: assert property ((|i_conds[3:0] || |i_comm) |-> ##2 o_alert)
      else $error("condition did not raise alert");
   a_flag_latched: assert property (o_alert && !clr && !$past(clr) |=> o_alert)
      else $error("alert dropped without clear");
   a_clear_release: assert property (clr && i_conds == '0 && i_comm == '0 |-> ##2 !o_alert)
      else $error("clear did not release alert");
   a_summary_bit: assert property (o_summary_word == {2'b00, o_input_summary, 13'h0000})
      else $error("summary word mismatch");
endmodule
bind power_status_telemetry_regs power_status_props u_props (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_req(i_req), .i_conds(i_conds), .i_comm(i_comm), .i_tele(i_tele),
   .i_tele_sample(i_tele_sample), .i_vout_exponent(i_vout_exponent), .o_rsp(o_rsp),
   .o_alert(o_alert), .o_input_summary(o_input_summary), .o_summary_word(o_summary_word));

// ==== bench/power_status_telemetry_regs_tb.sv ====
`timescale 1ns/1ps
`include "power_status_params.svh"
module power_status_telemetry_regs_tb
   import power_status_pkg::*;
();
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   cmd_req_t req;
   fault_conds_t conds = '0;
   comm_events_t comm = '0;
   telemetry_t tele = '0;
   logic tele_sample = 1'b0;
   logic [4:0] vexp = 5'h00;
   cmd_rsp_t rsp;
   logic alert;
   logic summ;
   logic [15:0] sword;
   int fails = 0;
   int check_count = 0;
   always #10 i_clk = ~i_clk;
   bus_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
   power_status_telemetry_regs uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req),
      .i_conds(conds), .i_comm(comm), .i_tele(tele), .i_tele_sample(tele_sample),
      .i_vout_exponent(vexp), .o_rsp(rsp), .o_alert(alert), .o_input_summary(summ),
      .o_summary_word(sword));
   // ==========
   // helpers
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic err,
      input logic two);
      cmd_rsp_t r;
      host.xfer(1'b0, c, r);
      cmp({13'h0000, r.valid, r.error, r.two_bytes}, {13'h0000, 1'b1, err, two});
      cmp(r.data, exp);
   endtask
   task automatic clear_all(input logic exp_alert);
      cmd_rsp_t r;
      host.xfer(1'b1, `CMD_CLEAR_FAULTS, r);
      cmp({15'h0000, r.error}, 16'h0000);
      @(posedge i_clk);
      #1;
      cmp({15'h0000, alert}, {15'h0000, exp_alert});
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      for (int c = `CMD_INPUT_STATUS; c <= `CMD_VENDOR_STATUS; c++) rd(8'(c), 16'h0000, 0, 0);
      for (int c = `CMD_INPUT_VOLTAGE_READING; c <= `CMD_READ_CHIP_TEMP; c++) rd(8'(c), 16'h0000, 0, 1);
      cmp({15'h0000, alert}, 16'h0000);
   endtask
   task automatic t_flags();
      logic [7:0] cd [11] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h31, 8'h31, 8'h33, 8'h33,
         8'h32, 8'h32, 8'h32};
      int bp [11] = '{4, 5, 6, 7, 6, 7, 6, 7, 1, 5, 7};
      for (int i = 0; i < 11; i++) begin
         @(posedge i_clk);
         if (i < 8) conds <= fault_conds_t'(8'h80 >> i);
         else comm <= comm_events_t'(3'h4 >> (i - 8));
         @(posedge i_clk);
         conds <= '0;
         comm <= '0;
         rd(cd[i], 16'h0001 << bp[i], 0, 0);
         cmp({15'h0000, alert}, 16'h0001);
         cmp(sword, (i < 4) ? 16'h2000 : 16'h0000);
         cmp({15'h0000, summ}, (i < 4) ? 16'h0001 : 16'h0000);
         clear_all(1'b0);
         rd(cd[i], 16'h0000, 0, 0);
      end
   endtask
   task automatic t_bad();
      rd(8'h7E, 16'h0000, 1, 0);
      rd(`CMD_CLEAR_FAULTS, 16'h0000, 1, 0);
      rd(`CMD_COMM_STATUS, 16'h0080, 0, 0);
      clear_all(1'b0);
   endtask
   task automatic t_persist();
      @(posedge i_clk);
      conds <= fault_conds_t'(8'h20);
      repeat (2) @(posedge i_clk);
      clear_all(1'b1);
      rd(`CMD_INPUT_STATUS, 16'h0040, 0, 0);
      @(posedge i_clk);
      conds <= '0;
      clear_all(1'b0);
   endtask
   task automatic t_tele();
      cmd_rsp_t r;
      logic [15:0] w [5] = '{16'h1234, 16'h8ABC, 16'h00FF, 16'hF00D, 16'h7FFE};
      @(posedge i_clk);
      tele <= {w[0], w[1], w[2], w[3], w[4]};
      tele_sample <= 1'b1;
      vexp <= 5'h13;
      @(posedge i_clk);
      tele_sample <= 1'b0;
      tele <= ~{w[0], w[1], w[2], w[3], w[4]};
      // the live inputs moved on, so only the held copy can match
      for (int i = 0; i < 5; i++) rd(8'(`CMD_INPUT_VOLTAGE_READING + i), w[i], 0, 1);
      rd(`CMD_OUTPUT_FORMAT, 16'h0013, 0, 0);
      host.xfer(1'b1, `CMD_INPUT_VOLTAGE_READING, r);
      cmp({15'h0000, r.error}, 16'h0000);
      cmp(r.data, 16'h0000);
      host.xfer(1'b1, `CMD_INPUT_STATUS, r);
      rd(`CMD_INPUT_STATUS, 16'h0000, 0, 0);
      rd(`CMD_INPUT_VOLTAGE_READING, w[0], 0, 1);
   endtask
   task automatic t_midreset();
      @(posedge i_clk);
      conds <= fault_conds_t'(8'h04);
      @(posedge i_clk);
      conds <= '0;
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      // a reset in mid-run drops latched flags and the held words alike
      rd(`CMD_EXT_TEMP_STATUS, 16'h0000, 0, 0);
      rd(`CMD_INPUT_VOLTAGE_READING, 16'h0000, 0, 1);
      cmp({15'h0000, alert}, 16'h0000);
   endtask
   // ==========
   // run control
   task automatic conclude();
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_reset();
      t_flags();
      t_bad();
      t_persist();
      t_tele();
      t_midreset();
      conclude();
   end
   initial begin
      #100000;
      fails++;
      conclude();
   end
endmodule
